// file: verilog/power_monitor_defines.vh
// Register offsets, field positions, reset values and timing counts
`ifndef POWER_MONITOR_DEFINES_VH
`define POWER_MONITOR_DEFINES_VH
// Byte addresses on the AXI4-Lite bus
`define OFS_CONFIG_BYTE 4'h0
`define OFS_MONITOR_CTRL 4'h4
`define OFS_POWER_CTRL 4'h8
`define OFS_IRQ_STATUS 4'hC
// Config byte fields
`define CFG_DISABLE_BIT 7
`define CFG_LEVEL_BIT 6
`define CFG_RESET_BIT 4
`define CFG_RESET_VALUE 8'hFF
// Monitor control fields
`define MCR_RESET_SEL_BIT 4
`define MCR_FLAG_BIT 3
`define MCR_LOW_POWER_BIT 2
`define MCR_RESET_VALUE 8'h00
// Power control field
`define PCR_POWER_ON_BIT 4
// Interrupt status bits
`define IRQ_BROWNOUT_BIT 0
`define IRQ_POWER_ON_BIT 1
// Sampling interval: 12.8 ms at 10 kHz slow clock, 0.1 ms ticks
`define SAMPLE_INTERVAL_US 12800
`define SLOW_CLK_HZ 10000
`define SLOW_PERIOD_US (1000000 / `SLOW_CLK_HZ)
`define SAMPLE_TICKS (`SAMPLE_INTERVAL_US / `SLOW_PERIOD_US)
// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// file: verilog/power_monitor_brownout.v
// Power-on flag, brownout detector control and AXI4-Lite registers
//
// The address map and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "power_monitor_defines.vh"
module power_monitor_brownout
(
    // System clock, reset and clock enable
    input wire clk_sys,
    input wire rst_b,
    input wire clk_en,
    // AXI4-Lite write address
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // AXI4-Lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // AXI4-Lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read address
    input wire [3:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // AXI4-Lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Analog side
    input wire power_up_done,
    input wire supply_below_async,
    input wire slow_rc_tick,
    output reg slow_rc_enable,
    output reg level_select_high,
    output reg hysteresis_enable,
    output reg comparator_enable,
    // CPU side
    output reg brownout_reset_req,
    output wire irq
);

    // Registers held by software
    reg [7:0] brownout_config_byte;
    reg reset_select;
    reg low_power_mode;
    reg brownout_flag;
    reg power_on_flag;
    reg [1:0] irq_status;
    reg [1:0] irq_enable;
    // Comparator synchroniser and sampled level
    reg below_meta;
    reg below_sync;
    reg below_level;
    // Slow tick counter for low-power sampling
    reg [7:0] tick_count;
    reg sample_now;
    // Power-up edge detector
    reg power_up_seen;
    // Write channel holding stages
    reg aw_held;
    reg [3:0] aw_addr;
    reg w_held;
    reg [31:0] w_data;
    reg [3:0] w_strb;
    // Derived configuration
    wire detect_enable;
    wire reset_mode;
    wire do_write;
    wire wr_lane0;
    wire brownout_event;
    wire recover_event;
    wire power_on_event;
    wire sw_clear_flag;
    wire sw_clear_power;
    wire wr_lane1_en;

    assign detect_enable = ~brownout_config_byte[`CFG_DISABLE_BIT];
    // Reset mode from config and select
    assign reset_mode = brownout_config_byte[`CFG_RESET_BIT] & reset_select;

    // Handshake readiness: one write and one read at a time
    assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
    assign s_axi_wready = ~w_held & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;
    assign do_write = aw_held & w_held & ~s_axi_bvalid & clk_en;
    assign wr_lane0 = do_write & w_strb[0];

    // Software clear strobes for the two flags
    assign sw_clear_flag = wr_lane0 & (aw_addr == `OFS_MONITOR_CTRL)
        & ~w_data[`MCR_FLAG_BIT];
    // Clear power-on flag by writing zero
    assign sw_clear_power = wr_lane0 & (aw_addr == `OFS_POWER_CTRL)
        & ~w_data[`PCR_POWER_ON_BIT];

    // Brownout falling and rising edges on the sampled level
    assign brownout_event = detect_enable & below_sync & ~below_level
        & (~low_power_mode | sample_now);
    assign recover_event = detect_enable & ~below_sync & below_level
        & (~low_power_mode | sample_now);
    assign power_on_event = power_up_done & ~power_up_seen;

    // Level interrupt while an enabled status bit is set
    assign irq = |(irq_status & irq_enable);

    always @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            below_meta <= 1'b0;
            below_sync <= 1'b0;
        end
        else if (clk_en)
        begin
            below_meta <= supply_below_async;
            below_sync <= below_meta;
        end
    end

    // Analog control outputs follow configuration
    always @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            slow_rc_enable <= 1'b0;
            level_select_high <= 1'b0;
            hysteresis_enable <= 1'b0;
            comparator_enable <= 1'b0;
        end
        else if (clk_en)
        begin
            // Slow RC runs only in low-power mode
            slow_rc_enable <= detect_enable & low_power_mode;
            // Level bit one selects 2.7V, zero 3.8V
            level_select_high <= ~brownout_config_byte[`CFG_LEVEL_BIT];
            hysteresis_enable <= detect_enable & ~low_power_mode;
            comparator_enable <= detect_enable;
        end
    end

    // Interval counter on slow RC ticks
    always @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            tick_count <= 8'h00;
            sample_now <= 1'b0;
        end
        else if (clk_en)
        begin
            sample_now <= 1'b0;
            if (!(detect_enable & low_power_mode))
                tick_count <= 8'h00;
            else if (slow_rc_tick)
            begin
                // Tick is assumed synchronous, one cycle wide
                if (tick_count == `SAMPLE_TICKS - 1)
                begin
                    tick_count <= 8'h00;
                    sample_now <= 1'b1;
                end
                else
                    tick_count <= tick_count + 8'h01;
            end
        end
    end

    // Sampled supply level and brownout flag, set beats clear
    always @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            below_level <= 1'b0;
            brownout_flag <= 1'b0;
            brownout_reset_req <= 1'b0;
        end
        else if (clk_en)
        begin
            if (!detect_enable)
                below_level <= 1'b0;
            else if (brownout_event | recover_event)
                below_level <= below_sync;
            // Reset request holds while below in reset mode
            brownout_reset_req <= reset_mode & detect_enable
                & (brownout_event | (below_level & ~recover_event));
            // Interrupt mode sets flag on drop and on recovery
            if (brownout_event & ~reset_mode)
                brownout_flag <= 1'b1;
            else if (recover_event & ~reset_mode)
                brownout_flag <= 1'b1;
            // Only edges set it, so a clear holds
            else if (sw_clear_flag)
                brownout_flag <= 1'b0;
        end
    end

    // Power-on flag set on completed power-up
    always @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            power_up_seen <= 1'b0;
            power_on_flag <= 1'b0;
        end
        else if (clk_en)
        begin
            power_up_seen <= power_up_done;
            if (power_on_event)
                power_on_flag <= 1'b1;
            else if (sw_clear_power)
                power_on_flag <= 1'b0;
        end
    end

    // Sticky interrupt status, enable and write-one-to-clear
    always @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            irq_status <= 2'h0;
            irq_enable <= 2'h0;
        end
        else if (clk_en)
        begin
            // Set wins over a clear in the same cycle
            if (wr_lane0 && aw_addr == `OFS_IRQ_STATUS)
                irq_status <= irq_status & ~w_data[1:0];
            if ((brownout_event | recover_event) & ~reset_mode)
                irq_status[`IRQ_BROWNOUT_BIT] <= 1'b1;
            if (power_on_event)
                irq_status[`IRQ_POWER_ON_BIT] <= 1'b1;
            if (wr_lane1_en)
                irq_enable <= w_data[9:8];
        end
    end

    // Interrupt enable sits in byte 1 of the status word
    assign wr_lane1_en = do_write & w_strb[1]
        & (aw_addr == `OFS_IRQ_STATUS);

    // Config byte and control register writes
    always @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            brownout_config_byte <= `CFG_RESET_VALUE;
            reset_select <= 1'b0;
            low_power_mode <= 1'b0;
        end
        else if (wr_lane0)
        begin
            if (aw_addr == `OFS_CONFIG_BYTE)
                // Reserved bits stay one
                brownout_config_byte <= w_data[7:0] | 8'h2F;
            else if (aw_addr == `OFS_MONITOR_CTRL)
            begin
                reset_select <= w_data[`MCR_RESET_SEL_BIT];
                low_power_mode <= w_data[`MCR_LOW_POWER_BIT];
            end
        end
    end

    // Write address/data capture and response
    always @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            aw_held <= 1'b0;
            aw_addr <= 4'h0;
            w_held <= 1'b0;
            w_data <= 32'h0;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
        end
        else if (clk_en)
        begin
            if (s_axi_awvalid & s_axi_awready)
            begin
                aw_held <= 1'b1;
                aw_addr <= {s_axi_awaddr[3:2], 2'b00};
            end
            if (s_axi_wvalid & s_axi_wready)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write)
            begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                // All four words are mapped in a 16-byte window
                s_axi_bresp <= `RESP_OKAY;
            end
            else if (s_axi_bvalid & s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // Read path, data registered one cycle after address
    always @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `RESP_OKAY;
        end
        else if (clk_en)
        begin
            if (s_axi_arvalid & s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `RESP_OKAY;
                case (s_axi_araddr[3:2])
                    2'h0: s_axi_rdata <= {24'h0, brownout_config_byte};
                    2'h1: s_axi_rdata <= {27'h0, reset_select,
                        brownout_flag, low_power_mode, 2'b00};
                    2'h2: s_axi_rdata <= {27'h0, power_on_flag, 4'h0};
                    default: s_axi_rdata <= {22'h0, irq_enable,
                        6'h0, irq_status};
                endcase
            end
            else if (s_axi_rvalid & s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// file: dv/power_monitor_brownout_assertions.sv
// Checker for the power monitor bus handshakes and analog controls
`timescale 1ns/10ps
`default_nettype none
module power_monitor_brownout_assertions (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // Bus handshakes
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic [1:0] s_axi_rresp,
    // Analog side
    input wire logic supply_below_async,
    input wire logic slow_rc_enable,
    input wire logic hysteresis_enable,
    input wire logic comparator_enable,
    input wire logic brownout_reset_req
);
    // One clock domain, so one default clock and reset
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    chk_slow_clock_mode: assert property
        (slow_rc_enable |-> comparator_enable && !hysteresis_enable)
        else $error("slow clock on outside low-power detection");
    chk_hyst_needs_detect: assert property
        (hysteresis_enable |-> comparator_enable)
        else $error("hysteresis on while detection is off");
    chk_reset_after_low: assert property
        ($rose(brownout_reset_req) |-> $past(supply_below_async, 3))
        else $error("reset request without a synchronised drop");
    chk_write_okay: assert property
        (s_axi_bvalid |-> s_axi_bresp == 2'h0)
        else $error("write response not okay");
    chk_read_answer: assert property
        (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    chk_read_blocked: assert property
        (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while data pending");
    chk_read_okay: assert property
        (s_axi_rvalid |-> s_axi_rresp == 2'h0)
        else $error("read response not okay");
    chk_write_blocked: assert property
        (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    chk_resp_drops: assert property
        (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
endmodule
bind power_monitor_brownout power_monitor_brownout_assertions chk (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .s_axi_awready(s_axi_awready),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rresp(s_axi_rresp),
    .supply_below_async(supply_below_async),
    .slow_rc_enable(slow_rc_enable),
    .hysteresis_enable(hysteresis_enable),
    .comparator_enable(comparator_enable),
    .brownout_reset_req(brownout_reset_req)
);
`default_nettype wire

// file: dv/supply_model.sv
// Behavioural supply comparator and slow RC oscillator
`timescale 1ns/10ps
`default_nettype none
module supply_model #(parameter int HYST_MV = 100, parameter int SLOW_DIV = 4)
(
    // Bench controls
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic power_good,
    input wire logic [15:0] vdd_mv,
    // Controls from the block
    input wire logic comparator_enable,
    input wire logic level_select_high,
    input wire logic hysteresis_enable,
    input wire logic slow_rc_enable,
    // Results to the block
    output logic supply_below_async,
    output logic slow_rc_tick,
    output logic power_up_done
);
    int thr; // Trip level in millivolts
    int div; // Slow clock divider, short to keep the run brief
    assign thr = level_select_high ? 3800 : 2700;
    // Comparator changes off the edge, like a real async output
    always @(posedge clk_sys)
    begin
        power_up_done <= power_good;
        if (!rst_b || !comparator_enable)
            supply_below_async <= #7 1'h0;
        else if (vdd_mv < thr)
            supply_below_async <= #7 1'h1;
        // release band only while hysteresis is on
        else if (!hysteresis_enable || vdd_mv >= thr + HYST_MV)
            supply_below_async <= #7 1'h0;
        div <= (slow_rc_enable && div < SLOW_DIV - 1) ? div + 1 : 0;
        slow_rc_tick <= rst_b && slow_rc_enable && div == SLOW_DIV - 1;
    end
endmodule
`default_nettype wire

// file: dv/power_monitor_brownout_test.sv
// Self-checking bench for the power monitor and brownout block
`timescale 1ns/10ps
`default_nettype none
module power_monitor_brownout_test;
    // Bench drives
    logic clk_sys = 1'h0, rst_b = 1'h0, power_good = 1'h0, clk_en = 1'h1;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic arvalid = 1'h0, rready = 1'h0;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0;
    logic [31:0] wdata = 32'h0, rd;
    logic [15:0] vdd_mv = 16'hFA0; // 4000 mV
    // Block outputs
    wire logic awready, wready, bvalid, arready, rvalid, irq;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata;
    wire logic below, tick, pud, rc_en, lvl, hyst, cmp, rst_req;
    int num_errors = 0, checked = 0, n;
    // Ordinary register cases: address, write, mask, read-back
    typedef struct {logic [3:0] a; logic [31:0] d, m, e;} row_t;
    row_t rows [4] = '{'{4'h0, 32'h0, 32'hFF, 32'h2F},
        '{4'h4, 32'h14, 32'h14, 32'h14}, '{4'h4, 32'h0, 32'h1C, 32'h0},
        '{4'hC, 32'h300, 32'h300, 32'h300}};
    power_monitor_brownout DUT (.clk_sys(clk_sys), .rst_b(rst_b),
        .clk_en(clk_en), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .power_up_done(pud),
        .supply_below_async(below), .slow_rc_tick(tick),
        .slow_rc_enable(rc_en), .level_select_high(lvl),
        .hysteresis_enable(hyst), .comparator_enable(cmp),
        .brownout_reset_req(rst_req), .irq(irq));
    supply_model #(.HYST_MV(100), .SLOW_DIV(4)) partner (.clk_sys(clk_sys),
        .rst_b(rst_b), .power_good(power_good), .vdd_mv(vdd_mv),
        .comparator_enable(cmp), .level_select_high(lvl),
        .hysteresis_enable(hyst), .slow_rc_enable(rc_en),
        .supply_below_async(below), .slow_rc_tick(tick),
        .power_up_done(pud));
    // 25 MHz clock
    initial
    begin
        forever #20 clk_sys = ~clk_sys;
    end
    task automatic ck(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic stop_test;
        $display("checked %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Bus write: both channels offered together, each dropped when taken
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        for (n = 0; n < 50 && !bvalid; n++)
        begin
            @(posedge clk_sys);
            if (awready)
                awvalid <= 1'h0;
            if (wready)
                wvalid <= 1'h0;
        end
        bready <= 1'h0;
        if (n == 50)
            ck(32'h0, 32'h1);
        if (n == 50)
            stop_test();
        @(posedge clk_sys);
    endtask
    // Bus read, masked compare against the expected word
    task automatic rc(input logic [3:0] a, input logic [31:0] m, e);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        for (n = 0; n < 50 && !rvalid; n++)
        begin
            @(posedge clk_sys);
            if (arready)
                arvalid <= 1'h0;
        end
        rd = rdata;
        rready <= 1'h0;
        if (n == 50)
        begin
            ck(32'h0, 32'h1);
            stop_test();
        end
        ck(rd & m, e);
        @(posedge clk_sys);
    endtask
    // Wait for the interrupt with a bound; n holds the cycles taken
    task automatic wait_irq;
        for (n = 0; n < 2000 && irq !== 1'h1; n++)
            @(posedge clk_sys);
    endtask
    initial
    begin
        repeat (16) @(posedge clk_sys);
        rst_b <= 1'h1;
        @(posedge clk_sys);
        rc(4'h0, 32'hFF, 32'hFF);
        ck({31'h0, cmp}, 32'h0);
        rc(4'h8, 32'h10, 32'h0);
        power_good <= 1'h1;
        repeat (4) @(posedge clk_sys);
        rc(4'h8, 32'h10, 32'h10);
        wr(4'h8, 32'h0);
        repeat (8) @(posedge clk_sys);
        rc(4'h8, 32'h10, 32'h0);
        rc(4'hC, 32'h2, 32'h2);
        foreach (rows[i])
        begin
            wr(rows[i].a, rows[i].d);
            rc(rows[i].a, rows[i].m, rows[i].e);
        end
        ck({31'h0, irq}, 32'h1);
        wr(4'hC, 32'h302);
        ck({31'h0, irq}, 32'h0);
        ck({29'h0, lvl, hyst, cmp}, 32'h7);
        // Interrupt mode: drop, clear while low, recover
        // Clock enable low freezes the synchroniser and flags
        clk_en <= 1'h0;
        vdd_mv <= 16'hDAC;
        repeat (8) @(posedge clk_sys);
        ck({31'h0, irq}, 32'h0);
        clk_en <= 1'h1;
        repeat (8) @(posedge clk_sys);
        rc(4'h4, 32'h8, 32'h8);
        ck({30'h0, rst_req, irq}, 32'h1);
        wr(4'h4, 32'h0);
        wr(4'hC, 32'h301);
        repeat (20) @(posedge clk_sys);
        rc(4'h4, 32'h8, 32'h0);
        vdd_mv <= 16'hFA0;
        repeat (8) @(posedge clk_sys);
        rc(4'h4, 32'h8, 32'h8);
        // Lower trip level ignores 3500 mV
        wr(4'h0, 32'h40);
        wr(4'h4, 32'h10);
        vdd_mv <= 16'hDAC;
        repeat (8) @(posedge clk_sys);
        rc(4'h4, 32'h8, 32'h0);
        ck({31'h0, lvl}, 32'h0);
        // Reset mode needs config reset bit and select
        wr(4'h0, 32'h10);
        repeat (8) @(posedge clk_sys);
        ck({31'h0, rst_req}, 32'h1);
        rc(4'h4, 32'h8, 32'h0);
        vdd_mv <= 16'hFA0;
        repeat (8) @(posedge clk_sys);
        ck({31'h0, rst_req}, 32'h0);
        wr(4'h0, 32'h0);
        vdd_mv <= 16'hDAC;
        repeat (8) @(posedge clk_sys);
        ck({31'h0, rst_req}, 32'h0);
        vdd_mv <= 16'hFA0;
        // Let recovery land before sampling starts, else level is stale
        repeat (8) @(posedge clk_sys);
        // Low-power mode: sampled, no hysteresis band
        wr(4'h4, 32'h4);
        wr(4'hC, 32'h301);
        ck({30'h0, rc_en, hyst}, 32'h2);
        vdd_mv <= 16'hDAC;
        wait_irq();
        ck({31'h0, n < 2000}, 32'h1);
        wr(4'hC, 32'h301);
        vdd_mv <= 16'hF0A;
        wait_irq();
        ck({31'h0, n > 440 && n < 520}, 32'h1);
        wr(4'h0, 32'h80);
        repeat (4) @(posedge clk_sys);
        ck({30'h0, cmp, rc_en}, 32'h0);
        stop_test();
    end
    // Run limit
    initial
    begin
        repeat (100000) @(posedge clk_sys);
        num_errors++;
        stop_test();
    end
endmodule
`default_nettype wire
